/* File: rtl/sync_two_ff.sv */
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes the inputs are levels from outside the ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// Levels
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] meta_q;
	if (WIDTH < 1) begin : g_width_check
		$error("WIDTH must be at least one");
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // sync_two_ff
`default_nettype wire

/* File: rtl/vertical_output_config_regs.sv */
// Vertical and shutter output configuration bank behind AXI4-Lite.
// Assumes pin-level inputs are asynchronous; one clock ref_clk.
//
// Behaviour
// - Pattern group count, five bits, sync-applied
// - Sequence count, five bits, sync-applied
// - Deep standby drives outputs from polarity field
// - Bias, shutter, strobe polarities in any standby
// - Sweep control selects legacy or extended toggles
// - First substrate output optionally XOR shutter zero
// - Second substrate output optionally XOR shutter zero
// - Combined shutter is shutter zero XOR shutter one or two
// - Three bits pick trigger field count
// - Trigger output only while enable set
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "vout_cfg.svh"
module vertical_output_config_regs (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 reset_n,
	// AXI4-Lite write address
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	// AXI4-Lite read data
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Timing core and pins
	input  wire logic                 verticalSync,
	input  wire logic                 outputEnableInput,
	input  wire vout_pkg::standby_t   standbyState,
	input  wire vout_pkg::vout_t      normalOutputs,
	input  wire vout_pkg::shut_t      shutterSignals,
	input  wire logic [2:0]           modeFieldCount,
	input  wire logic                 fieldTrigger,
	// Outputs to drivers and timing core
	output var  vout_pkg::vout_t      driverOutputs,
	output var  logic                 firstSubstrateOut,
	output var  logic                 secondSubstrateOut,
	output var  logic                 combinedShutterOut,
	output var  logic                 frameTriggerSignal,
	output var  logic [4:0]           patternGroupCount,
	output var  logic [4:0]           sequenceCount,
	output var  logic                 sweepCounterControl
);
	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	logic [1:0] pinSync;
	logic       vsyncLevel;
	logic       vsyncPrev_q;
	logic       outEnSync;
	logic       vsyncStrobe;

	sync_two_ff #(.WIDTH(2)) u_pin_sync (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn ({verticalSync, outputEnableInput}),
		.syncOut (pinSync)
	);
	assign vsyncLevel = pinSync[1];
	assign outEnSync  = pinSync[0];

	// Falling edge of the sync pin marks the field boundary
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			vsyncPrev_q <= 1'b0;
		end else begin
			vsyncPrev_q <= vsyncLevel;
		end
	end
	assign vsyncStrobe = vsyncPrev_q & ~vsyncLevel;

	////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [4:0]  patternStaged_q;
	logic [4:0]  sequenceStaged_q;
	logic [24:0] standbyPol_q;
	logic        sweepCtrl_q;
	logic [9:0]  startupTest_q;
	logic [15:0] muxTest_q;
	logic [3:0]  trigCtrl_q;
	logic        wrFire;
	logic [9:0]  wrIndex_q;
	logic [31:0] wData_q;
	logic        awHeld_q;
	logic        wHeld_q;
	vout_pkg::wr_state_t wrState_q;

	// Address and data are taken in either order and held until both exist
	assign s_axi_awready = ~awHeld_q & (wrState_q == vout_pkg::WR_IDLE);
	assign s_axi_wready  = ~wHeld_q & (wrState_q == vout_pkg::WR_IDLE);
	assign wrFire        = awHeld_q & wHeld_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld_q  <= 1'b0;
			wHeld_q   <= 1'b0;
			wrIndex_q <= 10'h000;
			wData_q   <= 32'h0000_0000;
			wrState_q <= vout_pkg::WR_IDLE;
			s_axi_bvalid <= 1'b0;
		end else begin
			case (wrState_q)
				vout_pkg::WR_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						awHeld_q  <= 1'b1;
						wrIndex_q <= s_axi_awaddr[11:2];
					end
					if (s_axi_wvalid && s_axi_wready) begin
						wHeld_q <= 1'b1;
						wData_q <= s_axi_wdata;
					end
					if (wrFire) begin
						awHeld_q     <= 1'b0;
						wHeld_q      <= 1'b0;
						s_axi_bvalid <= 1'b1;
						wrState_q    <= vout_pkg::WR_RESP;
					end
				end
				vout_pkg::WR_RESP: begin
					if (s_axi_bready) begin
						s_axi_bvalid <= 1'b0;
						wrState_q    <= vout_pkg::WR_IDLE;
					end
				end
				default: begin
					wrState_q <= vout_pkg::WR_IDLE;
				end
			endcase
		end
	end

	// Unmapped writes are accepted and dropped; all answers are OKAY
	assign s_axi_bresp = 2'b00;

	// Byte-lane merge; strobes that do not reach a field leave it alone
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [3:0]  wStrb_q;
	logic [31:0] mergeOld;
	logic [31:0] merged;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wStrb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wStrb_q <= s_axi_wstrb;
		end
	end

	always_comb begin
		mergeOld = 32'h0000_0000;
		case (wrIndex_q)
			10'(`IDX_PATTERN_GROUP_COUNT): mergeOld = {27'h0, patternStaged_q};
			10'(`IDX_SEQUENCE_COUNT):      mergeOld = {27'h0, sequenceStaged_q};
			10'(`IDX_DEEP_STANDBY_POL):    mergeOld = {7'h0, standbyPol_q};
			10'(`IDX_SWEEP_COUNTER_CTRL):  mergeOld = {31'h0, sweepCtrl_q};
			10'(`IDX_STARTUP_TEST_CONFIG): mergeOld = {22'h0, startupTest_q};
			10'(`IDX_OUTPUT_MUX_AND_TEST): mergeOld = {16'h0, muxTest_q};
			10'(`IDX_FRAME_TRIGGER_CTRL):  mergeOld = {28'h0, trigCtrl_q};
			default:                       mergeOld = 32'h0000_0000;
		endcase
	end
	assign merged = merge(mergeOld, wData_q, wStrb_q);

	// Staged copies of sync-applied registers land at once; core waits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			patternStaged_q  <= `RST_PATTERN_GROUP_COUNT;
			sequenceStaged_q <= `RST_SEQUENCE_COUNT;
		end else if (wrFire) begin
			if (wrIndex_q == 10'(`IDX_PATTERN_GROUP_COUNT)) begin
				patternStaged_q <= merged[4:0];
			end
			if (wrIndex_q == 10'(`IDX_SEQUENCE_COUNT)) begin
				sequenceStaged_q <= merged[4:0];
			end
		end
	end

	// Immediate registers apply on the completing write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			standbyPol_q  <= `RST_DEEP_STANDBY_POL;
			sweepCtrl_q   <= `RST_SWEEP_COUNTER_CTRL;
			startupTest_q <= `RST_STARTUP_TEST_CONFIG;
			muxTest_q     <= {`RST_MUX_BITS, `RST_TEST_FIELD_A};
			trigCtrl_q    <= `RST_FRAME_TRIGGER_CTRL;
		end else if (wrFire) begin
			case (wrIndex_q)
				10'(`IDX_DEEP_STANDBY_POL):    standbyPol_q  <= merged[24:0];
				10'(`IDX_SWEEP_COUNTER_CTRL):  sweepCtrl_q   <= merged[0];
				// Stored as written; start-up value is the host's duty
				10'(`IDX_STARTUP_TEST_CONFIG): startupTest_q <= merged[9:0];
				10'(`IDX_OUTPUT_MUX_AND_TEST): muxTest_q     <= merged[15:0];
				10'(`IDX_FRAME_TRIGGER_CTRL):  trigCtrl_q    <= merged[3:0];
				default: ;
			endcase
		end
	end

	// Count registers switch over only on the field boundary
	vsync_shadow #(.WIDTH(5)) u_pattern_shadow (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.staged  (patternStaged_q),
		.load    (vsyncStrobe),
		.active  (patternGroupCount)
	);
	vsync_shadow #(.WIDTH(5)) u_sequence_shadow (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.staged  (sequenceStaged_q),
		.load    (vsyncStrobe),
		.active  (sequenceCount)
	);

	////////////////////////////////////////////////////////////////////////
	// Read channel: one cycle after the address is taken
	logic [31:0] rdMux;
	logic [4:0]  standbyStatus;
	assign standbyStatus = {outEnSync, vsyncLevel, 1'b0, standbyState};
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		rdMux = 32'h0000_0000;
		case (s_axi_araddr[11:2])
			10'(`IDX_PATTERN_GROUP_COUNT): rdMux = {27'h0, patternStaged_q};
			10'(`IDX_SEQUENCE_COUNT):      rdMux = {27'h0, sequenceStaged_q};
			10'(`IDX_DEEP_STANDBY_POL):    rdMux = {7'h0, standbyPol_q};
			10'(`IDX_SWEEP_COUNTER_CTRL):  rdMux = {31'h0, sweepCtrl_q};
			10'(`IDX_STARTUP_TEST_CONFIG): rdMux = {22'h0, startupTest_q};
			10'(`IDX_OUTPUT_MUX_AND_TEST): rdMux = {16'h0, muxTest_q};
			10'(`IDX_FRAME_TRIGGER_CTRL):  rdMux = {28'h0, trigCtrl_q};
			10'(`IDX_STATUS): rdMux = {17'h0, sequenceCount, patternGroupCount,
				standbyStatus};
			default:                       rdMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdMux;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_rresp = 2'b00;

	////////////////////////////////////////////////////////////////////////
	// Output path, registered
	vout_pkg::vout_t polOut;
	logic            anyStandby;
	assign anyStandby = (standbyState != vout_pkg::STANDBY_NONE);
	// Bias, shutter and strobe fields sit at the top, same order as struct
	always_comb begin
		polOut = normalOutputs;
		if (standbyState == vout_pkg::STANDBY_THREE) begin
			polOut.verticalTransfer = standbyPol_q[12:0];
			polOut.sensorGate       = standbyPol_q[20:13];
			polOut.substrateClock   = standbyPol_q[`POS_SUBSTRATE_CLOCK];
		end
		if (anyStandby || !outEnSync) begin
			polOut.substrateBias     = standbyPol_q[`POS_SUBSTRATE_BIAS];
			polOut.mechanicalShutter = standbyPol_q[`POS_MECH_SHUTTER];
			polOut.strobe            = standbyPol_q[`POS_STROBE];
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			driverOutputs       <= '0;
			sweepCounterControl <= 1'b0;
		end else begin
			driverOutputs       <= polOut;
			sweepCounterControl <= sweepCtrl_q;
		end
	end

	// Shutter mux outputs; inputs are same-clock core signals
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			firstSubstrateOut  <= 1'b0;
			secondSubstrateOut <= 1'b0;
			combinedShutterOut <= 1'b0;
		end else begin
			firstSubstrateOut  <= shutterSignals.firstSubstrate ^
				(muxTest_q[`POS_FIRST_SUB_MUX] & shutterSignals.shutterZero);
			secondSubstrateOut <= shutterSignals.secondSubstrate ^
				(muxTest_q[`POS_SECOND_SUB_MUX] & shutterSignals.shutterZero);
			combinedShutterOut <= shutterSignals.shutterZero ^
				(muxTest_q[`POS_SHUTTER_PAIR_MUX] ? shutterSignals.shutterTwo
					: shutterSignals.shutterOne);
		end
	end

	// Trigger pulse on the selected field, gated by the enable bit
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			frameTriggerSignal <= 1'b0;
		end else begin
			frameTriggerSignal <= trigCtrl_q[`POS_TRIG_ENABLE] & fieldTrigger &
				(modeFieldCount == trigCtrl_q[2:0]);
		end
	end
endmodule // vertical_output_config_regs
`default_nettype wire

/* File: rtl/vout_cfg.svh */
// Offsets, field positions, reset values and timing counts of the
// vertical output configuration bank.
// Assumes inclusion by bare name; definitions only.
`ifndef VOUT_CFG_SVH
`define VOUT_CFG_SVH
// Printed offsets are register indices; byte address is four times each
`define IDX_PATTERN_GROUP_COUNT 8'h90
`define IDX_SEQUENCE_COUNT      8'h91
`define IDX_DEEP_STANDBY_POL    8'he2
`define IDX_SWEEP_COUNTER_CTRL  8'he6
`define IDX_STARTUP_TEST_CONFIG 8'hea
`define IDX_OUTPUT_MUX_AND_TEST 8'heb
`define IDX_FRAME_TRIGGER_CTRL  8'hf1
`define IDX_STATUS              8'hf8
`define RST_PATTERN_GROUP_COUNT 5'h00
`define RST_SEQUENCE_COUNT      5'h00
`define RST_DEEP_STANDBY_POL    25'h000_0000
`define RST_SWEEP_COUNTER_CTRL  1'h0
`define RST_STARTUP_TEST_CONFIG 10'h000
`define RST_TEST_FIELD_A        12'h300
`define RST_MUX_BITS            4'h0
`define RST_FRAME_TRIGGER_CTRL  4'h0
`define REQ_STARTUP_TEST_CONFIG 10'h060
`define POS_FIRST_SUB_MUX       12
`define POS_SECOND_SUB_MUX      13
`define POS_TEST_BIT_B          14
`define POS_SHUTTER_PAIR_MUX    15
`define POS_TRIG_ENABLE         3
`define POS_SUBSTRATE_CLOCK     21
`define POS_SUBSTRATE_BIAS      22
`define POS_MECH_SHUTTER        23
`define POS_STROBE              24
`define SYNC_STAGES             2
`endif

/* File: rtl/vout_pkg.sv */
// Types of the vertical output configuration bank.
// Assumes vout_cfg.svh holds the numbers.
package vout_pkg;
	typedef enum logic [1:0] {
		STANDBY_NONE,
		STANDBY_ONE,
		STANDBY_TWO,
		STANDBY_THREE
	} standby_t;
	typedef struct packed {
		logic [12:0] verticalTransfer;
		logic [7:0]  sensorGate;
		logic        substrateClock;
		logic        substrateBias;
		logic        mechanicalShutter;
		logic        strobe;
	} vout_t;
	typedef struct packed {
		logic shutterZero;
		logic shutterOne;
		logic shutterTwo;
		logic firstSubstrate;
		logic secondSubstrate;
	} shut_t;
	typedef enum logic [1:0] {
		WR_IDLE,
		WR_RESP
	} wr_state_t;
endpackage

/* File: rtl/vsync_shadow.sv */
// Holding register that takes a staged value only on a sync strobe.
// Assumes load is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module vsync_shadow #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// Staged value and strobe
	input  wire logic [WIDTH-1:0] staged,
	input  wire logic             load,
	output var  logic [WIDTH-1:0] active
);
	if (WIDTH < 1) begin : g_width_check
		$error("WIDTH must be at least one");
	end
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			active <= '0;
		end else if (load) begin
			active <= staged;
		end
	end
endmodule // vsync_shadow
`default_nettype wire

/* File: tb/test_vertical_output_config_regs.sv */
// Bus-driven tests of the vertical output configuration bank.
// Assumes the design files and vout_cfg.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "vout_cfg.svh"
module test_vertical_output_config_regs;
	logic               ref_clk, reset_n, awV, awR, wV, wR, bV, bR;
	logic               arV, arR, rV, rR, vSync, oe, fTrig;
	logic               sub0, sub1, cShut, trigOut, sweep;
	logic [11:0]        awAddr, arAddr;
	logic [31:0]        wD, rD;
	logic [3:0]         wS;
	logic [1:0]         bResp, rResp;
	logic [2:0]         mode;
	logic [4:0]         pgc, sqc;
	vout_pkg::standby_t st;
	vout_pkg::vout_t    nOut, dOut;
	vout_pkg::shut_t    shut;
	int                 n_errors, check_count;
	logic [7:0]  idxT [8] = '{`IDX_PATTERN_GROUP_COUNT, `IDX_SEQUENCE_COUNT,
		`IDX_DEEP_STANDBY_POL, `IDX_SWEEP_COUNTER_CTRL,
		`IDX_STARTUP_TEST_CONFIG, `IDX_OUTPUT_MUX_AND_TEST,
		`IDX_FRAME_TRIGGER_CTRL, 8'h10};
	logic [31:0] rstT [8] = '{0, 0, 0, 0, 0, 32'h0000_0300, 0, 0};
	logic [31:0] mskT [8] = '{32'h0000_001f, 32'h0000_001f, 32'h01ff_ffff,
		32'h0000_0001, 0, 0, 32'h0000_000f, 0};
	vertical_output_config_regs i_dut (
		.ref_clk, .reset_n, .s_axi_awaddr(awAddr), .s_axi_awvalid(awV),
		.s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(wS),
		.s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp),
		.s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
		.s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(rR),
		.verticalSync(vSync), .outputEnableInput(oe), .standbyState(st),
		.normalOutputs(nOut), .shutterSignals(shut), .modeFieldCount(mode),
		.fieldTrigger(fTrig), .driverOutputs(dOut),
		.firstSubstrateOut(sub0), .secondSubstrateOut(sub1),
		.combinedShutterOut(cShut), .frameTriggerSignal(trigOut),
		.patternGroupCount(pgc), .sequenceCount(sqc),
		.sweepCounterControl(sweep));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask
	// A wait that ran out ends the run rather than hang later tests
	task automatic bound(input int c);
		if (c >= 50) begin
			n_errors++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		int c;
		logic aDone, dDone;
		aDone = 1'b0;
		dDone = 1'b0;
		@(posedge ref_clk);
		awAddr <= {2'b00, idx, 2'b00};
		wD <= d;
		awV <= 1'b1;
		wV <= 1'b1;
		bR <= 1'b1;
		for (c = 0; c < 50 && !(aDone && dDone); c++) begin
			@(posedge ref_clk);
			if (!aDone && awR === 1'b1) begin
				aDone = 1'b1;
				awV <= 1'b0;
			end
			if (!dDone && wR === 1'b1) begin
				dDone = 1'b1;
				wV <= 1'b0;
			end
		end
		bound(c);
		for (c = 0; c < 50 && bV !== 1'b1; c++)
			@(posedge ref_clk);
		bR <= 1'b0;
		bound(c);
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] d);
		int c;
		@(posedge ref_clk);
		arAddr <= {2'b00, idx, 2'b00};
		arV <= 1'b1;
		rR <= 1'b1;
		// Wait at least one edge so the request is seen before release
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (c < 50 && arR !== 1'b1);
		arV <= 1'b0;
		bound(c);
		for (c = 0; c < 50 && rV !== 1'b1; c++)
			@(posedge ref_clk);
		d = rD;
		rR <= 1'b0;
		bound(c);
	endtask
	function automatic vout_pkg::vout_t expOut(input logic [24:0] p,
		input vout_pkg::vout_t nv, input logic full, input logic part);
		vout_pkg::vout_t r;
		r = nv;
		if (full) begin
			r.verticalTransfer = p[12:0];
			r.sensorGate = p[20:13];
			r.substrateClock = p[21];
		end
		if (full || part) begin
			r.substrateBias = p[22];
			r.mechanicalShutter = p[23];
			r.strobe = p[24];
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] v, p;
		vout_pkg::vout_t e;
		int i, k, m, c;
		{reset_n, awV, wV, bR, arV, rR, vSync, fTrig} = 8'h00;
		{awAddr, arAddr, wD, mode} = '0;
		wS = 4'hf;
		oe = 1'b1;
		st = vout_pkg::STANDBY_NONE;
		nOut = vout_pkg::vout_t'(25'h0f0_f0f5);
		shut = vout_pkg::shut_t'(5'h00);
		n_errors = 0;
		check_count = 0;
		tick(12);
		reset_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			rd(idxT[i], v);
			check("reset value", v, rstT[i]);
		end
		for (i = 0; i < 8; i++) begin
			if (i != 4 && i != 5) begin
				wr(idxT[i], 32'hffff_ffff);
				rd(idxT[i], v);
				check("field width", v, mskT[i]);
			end
		end
		check("count before sync", {27'h0, pgc}, 0);
		check("sweep applied", {31'h0, sweep}, 1);
		wr(`IDX_STARTUP_TEST_CONFIG, 32'h0000_0060);
		rd(`IDX_STARTUP_TEST_CONFIG, v);
		check("startup field", v, 32'h0000_0060);
		$display("Test registers done");
		p = 32'h0;
		for (k = 0; k < 2; k++) begin
			v = k ? 32'h0000_0015 : 32'h0000_000a;
			wr(`IDX_PATTERN_GROUP_COUNT, v);
			wr(`IDX_SEQUENCE_COUNT, v ^ 32'h0000_001f);
			tick(8);
			check("pattern held", {27'h0, pgc}, p);
			vSync <= 1'b1;
			tick(8);
			check("pattern held on rise", {27'h0, pgc}, p);
			vSync <= 1'b0;
			for (c = 0; c < 50 && pgc !== v[4:0]; c++)
				tick(1);
			bound(c);
			check("sequence applied", {27'h0, sqc}, v ^ 32'h1f);
			p = v;
		end
		$display("Test sync update done");
		wr(`IDX_DEEP_STANDBY_POL, 32'h01a5_c3f0);
		for (k = 0; k < 8; k++) begin
			st <= vout_pkg::standby_t'(k[1:0]);
			oe <= k[2];
			tick(6);
			e = expOut(25'h1a5_c3f0, nOut, k[1:0] == 2'd3,
				k[1:0] != 2'd0 || !k[2]);
			check("driver outputs", {7'h0, dOut}, {7'h0, e});
		end
		st <= vout_pkg::STANDBY_NONE;
		oe <= 1'b1;
		$display("Test standby done");
		for (k = 0; k < 8; k++) begin
			wr(`IDX_OUTPUT_MUX_AND_TEST,
				{16'h0, k[2], 1'b0, k[1], k[0], 12'h300});
			for (m = 0; m < 32; m++) begin
				shut <= vout_pkg::shut_t'(m[4:0]);
				tick(2);
				check("first substrate", sub0, (k[0] & m[4]) ^ m[1]);
				check("second substrate", sub1, (k[1] & m[4]) ^ m[0]);
				check("shutter", cShut, m[4] ^ (k[2] ? m[2] : m[3]));
			end
		end
		rd(`IDX_OUTPUT_MUX_AND_TEST, v);
		check("mux readback", v, 32'h0000_b300);
		$display("Test output mux done");
		fTrig <= 1'b1;
		for (k = 0; k < 16; k++) begin
			wr(`IDX_FRAME_TRIGGER_CTRL, k);
			for (m = 0; m < 8; m++) begin
				mode <= m[2:0];
				tick(2);
				check("frame trigger", trigOut, k[3] && k[2:0] == m[2:0]);
			end
		end
		fTrig <= 1'b0;
		$display("Test frame trigger done");
		print_verdict();
	end
endmodule // test_vertical_output_config_regs
`default_nettype wire

/* File: tb/vertical_output_config_regs_checker.sv */
// Port-level checks of the vertical output configuration bank.
// Assumes a bind into vertical_output_config_regs; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module vertical_output_config_regs_checker (
	// Clock and reset
	input wire logic               ref_clk,
	input wire logic               reset_n,
	// Bus
	input wire logic               s_axi_awvalid,
	input wire logic               s_axi_awready,
	input wire logic               s_axi_wvalid,
	input wire logic               s_axi_wready,
	input wire logic [1:0]         s_axi_bresp,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic [1:0]         s_axi_rresp,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready,
	// Pins and outputs
	input wire logic               verticalSync,
	input wire logic               outputEnableInput,
	input wire vout_pkg::standby_t standbyState,
	input wire vout_pkg::vout_t    normalOutputs,
	input wire vout_pkg::shut_t    shutterSignals,
	input wire logic               fieldTrigger,
	input wire vout_pkg::vout_t    driverOutputs,
	input wire logic               firstSubstrateOut,
	input wire logic               combinedShutterOut,
	input wire logic               frameTriggerSignal,
	input wire logic [4:0]         patternGroupCount,
	input wire logic [4:0]         sequenceCount
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////////////////
	// Cycles since the sync pin fell, and cycles the enable pin stood high
	logic [3:0] sinceFall;
	logic       vsPrev;
	logic [2:0] enCnt;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			vsPrev    <= 1'b0;
			sinceFall <= 4'hf;
			enCnt     <= 3'h0;
		end else begin
			vsPrev <= verticalSync;
			if (vsPrev && !verticalSync)
				sinceFall <= 4'h0;
			else if (sinceFall != 4'hf)
				sinceFall <= sinceFall + 4'h1;
			if (!outputEnableInput)
				enCnt <= 3'h0;
			else if (enCnt != 3'h7)
				enCnt <= enCnt + 3'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00)
		else $error("write response not okay");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped early");
	chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && s_axi_rresp == 2'b00)
		else $error("read data not held");
	chk_write_answer: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (rdTaken |=> s_axi_rvalid)
		else $error("read data late");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while data pending");
	chk_pattern_sync: assert property (patternGroupCount !=
		$past(patternGroupCount) |-> sinceFall inside {[1:6]})
		else $error("pattern count changed off sync");
	chk_sequence_sync: assert property (sequenceCount !=
		$past(sequenceCount) |-> sinceFall inside {[1:6]})
		else $error("sequence count changed off sync");
	chk_trigger_cause: assert property (frameTriggerSignal |->
		$past(fieldTrigger)) else $error("trigger without field pulse");
	chk_normal_pass: assert property (enCnt >= 3'h5 &&
		$past(standbyState) == vout_pkg::STANDBY_NONE |->
		driverOutputs == $past(normalOutputs))
		else $error("outputs not passed through");
	chk_shutter_pair: assert property (combinedShutterOut ==
		$past(shutterSignals.shutterZero ^ shutterSignals.shutterOne) ||
		combinedShutterOut ==
		$past(shutterSignals.shutterZero ^ shutterSignals.shutterTwo))
		else $error("combined shutter from no source");
	chk_substrate_pair: assert property (firstSubstrateOut ==
		$past(shutterSignals.firstSubstrate) || firstSubstrateOut ==
		$past(shutterSignals.shutterZero ^ shutterSignals.firstSubstrate))
		else $error("substrate output from no source");
endmodule // vertical_output_config_regs_checker
bind vertical_output_config_regs vertical_output_config_regs_checker
	i_chk (.ref_clk, .reset_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .verticalSync,
	.outputEnableInput, .standbyState, .normalOutputs, .shutterSignals,
	.fieldTrigger, .driverOutputs, .firstSubstrateOut, .combinedShutterOut,
	.frameTriggerSignal, .patternGroupCount, .sequenceCount);
`default_nettype wire
